// ### rtl/pimr_pkg.sv
// package: descriptor field layout, register map and codes for the microframe results block
package pimr_pkg;
    localparam int NUM_SLOTS = 8;
    localparam int COUNT_W   = 12;
    localparam int CODE_W    = 3;
    // result code bits
    localparam int CODE_XACT_ERR = 0;
    localparam int CODE_BABBLE   = 1;
    localparam int CODE_UNDERRUN = 2;
    // descriptor word four: result code of slot s (2 to 7) sits at 8 + 3*s
    localparam int W4_CODE_BASE  = 8;
    localparam int W4_ENABLE_LSB = 0;
    // descriptor word six (low half) / five (high half, bits 63:32 as 31:0)
    localparam int W6_SLOT5_LO_MSB = 31;
    localparam int W6_SLOT5_LO_LSB = 28;
    localparam int W6_SLOT4_LSB    = 16;
    localparam int W6_SLOT3_LSB    = 4;
    localparam int W6_SLOT2_HI_LSB = 0;
    localparam int W5_SLOT2_LO_LSB = 24;
    localparam int W5_SLOT1_LSB    = 12;
    localparam int W5_SLOT0_LSB    = 0;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_FRAME  = 8'h04;
    localparam logic [7:0] ADDR_WORD4  = 8'h08;
    localparam logic [7:0] ADDR_WORD5  = 8'h0c;
    localparam logic [7:0] ADDR_WORD6  = 8'h10;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MK = 8'h18;
    localparam logic [7:0] ADDR_RESULT = 8'h1c;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [4:0] FRAME_RESET = 5'h00;
endpackage : pimr_pkg

// ### rtl/pimr_slot_writer.sv
// per-slot write of count and code into the descriptor words
`timescale 1ns/1ps
module pimr_slot_writer (
    input  wire logic [31:0] word4_i,   // current word four
    input  wire logic [31:0] word5_i,   // current word five (bits 63:32)
    input  wire logic [31:0] word6_i,   // current word six
    input  wire logic        we_i,      // slot result valid and allowed
    input  wire logic [2:0]  slot_i,    // microframe index
    input  wire logic [11:0] count_i,   // received bytes
    input  wire logic [2:0]  code_i,    // result code
    output logic      [31:0] word4_o,   // updated word four
    output logic      [31:0] word5_o,   // updated word five
    output logic      [31:0] word6_o    // updated word six
);
    always_comb begin
        word4_o = word4_i;
        word5_o = word5_i;
        word6_o = word6_i;
        if (we_i) begin
            if (slot_i >= 3'h2) begin
                word4_o[pimr_pkg::W4_CODE_BASE + 3*int'(slot_i) +: pimr_pkg::CODE_W] = code_i;
            end
            word4_o[pimr_pkg::W4_ENABLE_LSB + int'(slot_i)] = 1'b0;
            case (slot_i)
                3'h0: word5_o[pimr_pkg::W5_SLOT0_LSB +: 12] = count_i;
                3'h1: word5_o[pimr_pkg::W5_SLOT1_LSB +: 12] = count_i;
                3'h2: begin
                    word5_o[pimr_pkg::W5_SLOT2_LO_LSB +: 8] = count_i[7:0];
                    word6_o[pimr_pkg::W6_SLOT2_HI_LSB +: 4] = count_i[11:8];
                end
                3'h3: word6_o[pimr_pkg::W6_SLOT3_LSB +: 12] = count_i;
                3'h4: word6_o[pimr_pkg::W6_SLOT4_LSB +: 12] = count_i;
                3'h5: word6_o[pimr_pkg::W6_SLOT5_LO_MSB:pimr_pkg::W6_SLOT5_LO_LSB] = count_i[3:0];
                default: ; // slots 6 and 7 counts live in word seven, outside this block
            endcase
        end
    end
endmodule : pimr_slot_writer

// ### rtl/pimr_top.sv
// microframe results writeback into a periodic transfer descriptor, AXI4-Lite slave
// Behaviour
// - slot 5 enabled, frame matches: count bits 3:0 into word six 31:28
// - slot 4 enabled, frame matches: full count into word six 27:16
// - slot 3 enabled, frame matches: full count into word six 15:4
// - slot 2 enabled, frame matches: count bits 11:8 into word six 3:0
// - slot 2 enabled, frame matches: count bits 7:0 into word five 63:56
// - slot 1 enabled, frame matches: full count into word five 55:44
// - slot 0 enabled, frame matches: full count into word five 43:32
// - slot 7 result code into word four 31:29
// - slot 6 result code into word four 28:26
// - slot 5 result code into word four 25:23
// - slot 4 result code into word four 22:20
// - slot 3 result code into word four 19:17
// - slot 2 result code into word four 16:14
// - code bit 0 transaction error, bit 1 babble on IN, bit 2 underrun on OUT
// - software sets enables; device serves only enabled slots, clears each after
`timescale 1ns/1ps
module pimr_top (
    input  wire logic        aclk,          // 10 MHz clock
    input  wire logic        aresetn,       // synchronous reset, active low
    // usb side result event
    input  wire logic        res_valid,     // one-cycle pulse: a slot was serviced
    input  wire logic [2:0]  res_slot,      // microframe index
    input  wire logic [4:0]  res_frame,     // bus frame number bits
    input  wire logic        res_is_in,     // 1 IN token, 0 OUT token
    input  wire logic [11:0] res_count,     // bytes received
    input  wire logic        res_xact_err,  // transaction error seen
    input  wire logic        res_babble,    // babble seen
    input  wire logic        res_underrun,  // underrun seen
    output logic [7:0]       slot_enable,   // pending slot enables for the scheduler
    // axi4-lite
    input  wire logic [7:0]  s_awaddr,      // write address
    input  wire logic        s_awvalid,     // write address valid
    output logic             s_awready,     // write address ready
    input  wire logic [31:0] s_wdata,       // write data
    input  wire logic [3:0]  s_wstrb,       // byte strobes
    input  wire logic        s_wvalid,      // write data valid
    output logic             s_wready,      // write data ready
    output logic [1:0]       s_bresp,       // write response
    output logic             s_bvalid,      // write response valid
    input  wire logic        s_bready,      // write response ready
    input  wire logic [7:0]  s_araddr,      // read address
    input  wire logic        s_arvalid,     // read address valid
    output logic             s_arready,     // read address ready
    output logic [31:0]      s_rdata,       // read data
    output logic [1:0]       s_rresp,       // read response
    output logic             s_rvalid,      // read data valid
    input  wire logic        s_rready,      // read data ready
    output logic             irq            // level interrupt
);
    // registers
    logic [31:0] word4_q, word4_d, word5_q, word5_d, word6_q, word6_d;
    logic [4:0]  frame_q, frame_d;
    logic        run_q, run_d;
    logic [7:0]  ist_q, ist_d, imask_q, imask_d;
    logic [31:0] last_q, last_d;
    // axi state
    logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
    logic [7:0]  awa_q, awa_d;
    logic [31:0] wd_q, wd_d, rd_q, rd_d;
    logic [3:0]  ws_q, ws_d;
    logic [1:0]  br_q, br_d, rr_q, rr_d;

    logic        hit;
    logic [2:0]  code;
    logic [31:0] w4_new, w5_new, w6_new;
    logic        do_write;

    // only taken when the frame matches and the slot is enabled
    assign hit = res_valid && run_q && (res_frame == frame_q)
               && word4_q[pimr_pkg::W4_ENABLE_LSB + int'(res_slot)];

    always_comb begin
        code = 3'h0;
        code[pimr_pkg::CODE_XACT_ERR] = res_xact_err;
        code[pimr_pkg::CODE_BABBLE]   = res_babble && res_is_in;
        code[pimr_pkg::CODE_UNDERRUN] = res_underrun && !res_is_in;
    end

    pimr_slot_writer u_writer (
        .word4_i (word4_q),
        .word5_i (word5_q),
        .word6_i (word6_q),
        .we_i    (hit),
        .slot_i  (res_slot),
        .count_i (res_count),
        .code_i  (code),
        .word4_o (w4_new),
        .word5_o (w5_new),
        .word6_o (w6_new)
    );

    assign slot_enable = word4_q[7:0];
    assign do_write    = aw_q && w_q && !bv_q;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // register file and hardware writeback
    always_comb begin
        word4_d = w4_new;
        word5_d = w5_new;
        word6_d = w6_new;
        frame_d = frame_q;
        run_d   = run_q;
        imask_d = imask_q;
        last_d  = last_q;
        ist_d   = ist_q;
        if (hit) begin
            last_d = {16'h0000, 1'b0, code, res_slot, 1'b1, res_count[7:0]};
        end
        if (do_write) begin
            case (awa_q)
                pimr_pkg::ADDR_CTRL:   if (ws_q[0]) run_d = wd_q[0];
                pimr_pkg::ADDR_FRAME:  if (ws_q[0]) frame_d = wd_q[4:0];
                // software may set enables alongside hardware clears; software bytes win
                pimr_pkg::ADDR_WORD4:  word4_d = merge(w4_new, wd_q, ws_q);
                pimr_pkg::ADDR_WORD5:  word5_d = merge(w5_new, wd_q, ws_q);
                pimr_pkg::ADDR_WORD6:  word6_d = merge(w6_new, wd_q, ws_q);
                pimr_pkg::ADDR_IRQ_ST: if (ws_q[0]) ist_d = ist_q & ~wd_q[7:0];
                pimr_pkg::ADDR_IRQ_MK: if (ws_q[0]) imask_d = wd_q[7:0];
                default: ;
            endcase
        end
        // set wins over a simultaneous write-one clear
        if (hit) begin
            ist_d[res_slot] = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            word4_q <= 32'h0000_0000;
            word5_q <= 32'h0000_0000;
            word6_q <= 32'h0000_0000;
            frame_q <= pimr_pkg::FRAME_RESET;
            run_q   <= 1'b0;
            ist_q   <= 8'h00;
            imask_q <= 8'h00;
            last_q  <= 32'h0000_0000;
        end else begin
            word4_q <= word4_d;
            word5_q <= word5_d;
            word6_q <= word6_d;
            frame_q <= frame_d;
            run_q   <= run_d;
            ist_q   <= ist_d;
            imask_q <= imask_d;
            last_q  <= last_d;
        end
    end

    assign irq = |(ist_q & imask_q);

    // axi4-lite handshakes
    assign s_awready = !aw_q;
    assign s_wready  = !w_q;
    assign s_bvalid  = bv_q;
    assign s_bresp   = br_q;
    assign s_arready = !rv_q;
    assign s_rvalid  = rv_q;
    assign s_rdata   = rd_q;
    assign s_rresp   = rr_q;

    always_comb begin
        aw_d = aw_q;
        w_d  = w_q;
        bv_d = bv_q;
        awa_d = awa_q;
        wd_d = wd_q;
        ws_d = ws_q;
        br_d = br_q;
        rv_d = rv_q;
        rd_d = rd_q;
        rr_d = rr_q;
        if (s_awvalid && !aw_q) begin
            aw_d  = 1'b1;
            awa_d = {s_awaddr[7:2], 2'b00};
        end
        if (s_wvalid && !w_q) begin
            w_d  = 1'b1;
            wd_d = s_wdata;
            ws_d = s_wstrb;
        end
        if (do_write) begin
            bv_d = 1'b1;
            br_d = (awa_q <= pimr_pkg::ADDR_IRQ_MK) ? pimr_pkg::RESP_OKAY : pimr_pkg::RESP_SLVERR;
        end
        if (bv_q && s_bready) begin
            bv_d = 1'b0;
            aw_d = 1'b0;
            w_d  = 1'b0;
        end
        if (s_arvalid && !rv_q) begin
            rv_d = 1'b1;
            rr_d = pimr_pkg::RESP_OKAY;
            case ({s_araddr[7:2], 2'b00})
                pimr_pkg::ADDR_CTRL:   rd_d = {31'h0, run_q};
                pimr_pkg::ADDR_FRAME:  rd_d = {27'h0, frame_q};
                pimr_pkg::ADDR_WORD4:  rd_d = word4_q;
                pimr_pkg::ADDR_WORD5:  rd_d = word5_q;
                pimr_pkg::ADDR_WORD6:  rd_d = word6_q;
                pimr_pkg::ADDR_IRQ_ST: rd_d = {24'h0, ist_q};
                pimr_pkg::ADDR_IRQ_MK: rd_d = {24'h0, imask_q};
                pimr_pkg::ADDR_RESULT: rd_d = last_q;
                default: begin
                    rd_d = 32'h0000_0000;
                    rr_d = pimr_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rv_q && s_rready) begin
            rv_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q  <= 1'b0;
            w_q   <= 1'b0;
            bv_q  <= 1'b0;
            awa_q <= 8'h00;
            wd_q  <= 32'h0000_0000;
            ws_q  <= 4'h0;
            br_q  <= 2'h0;
            rv_q  <= 1'b0;
            rd_q  <= 32'h0000_0000;
            rr_q  <= 2'h0;
        end else begin
            aw_q  <= aw_d;
            w_q   <= w_d;
            bv_q  <= bv_d;
            awa_q <= awa_d;
            wd_q  <= wd_d;
            ws_q  <= ws_d;
            br_q  <= br_d;
            rv_q  <= rv_d;
            rd_q  <= rd_d;
            rr_q  <= rr_d;
        end
    end
endmodule : pimr_top

// ### sim/pimr_usb_model.sv
// usb side model: hands over one serviced-slot result per call
`timescale 1ns/1ps
module pimr_usb_model (
    input  wire logic  aclk,       // clock
    output logic       res_valid,  // result strobe
    output logic [2:0] res_slot,   // slot
    output logic [4:0] res_frame,  // frame number
    output logic       res_is_in,  // token kind
    output logic [11:0] res_count, // bytes
    output logic [2:0] res_flags   // underrun, babble, error
);
    initial begin
        {res_valid, res_slot, res_frame, res_is_in, res_count, res_flags} = '0;
    end
    task automatic send(input logic [2:0] s, input logic [4:0] f, input logic [11:0] c,
                        input logic i, input logic [2:0] e);
        @(posedge aclk);
        {res_valid, res_slot, res_frame, res_is_in, res_count, res_flags} <= {1'b1, s, f, i, c, e};
        @(posedge aclk);
        // stale slot, frame and count inverted so nothing leans on their held values
        {res_valid, res_slot, res_frame, res_count} <= {1'b0, ~s, ~f, ~c};
        #1;
    endtask : send
endmodule : pimr_usb_model

// ### sim/pimr_top_props.sv
// checker: bus handshakes, slot enables and interrupt cause
`timescale 1ns/1ps
module pimr_top_props (
    input wire logic        aclk,        // clock
    input wire logic        aresetn,     // reset
    input wire logic        res_valid,   // result
    input wire logic [2:0]  res_slot,    // slot
    input wire logic [7:0]  slot_enable, // enables
    input wire logic        s_awvalid,   // aw
    input wire logic        s_awready,   // aw
    input wire logic        s_wvalid,    // w
    input wire logic        s_wready,    // w
    input wire logic [1:0]  s_bresp,     // b
    input wire logic        s_bvalid,    // b
    input wire logic        s_bready,    // b
    input wire logic        s_arvalid,   // ar
    input wire logic        s_arready,   // ar
    input wire logic [31:0] s_rdata,     // r
    input wire logic        s_rvalid,    // r
    input wire logic        s_rready,    // r
    input wire logic        irq          // interrupt
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_wr_resp;
        s_awvalid && s_awready && s_wvalid && s_wready |-> ##[1:2] s_bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
    property p_aw_block;
        s_awvalid && s_awready && s_wvalid && s_wready |=> !s_awready && !s_wready;
    endproperty
    a_aw_block: assert property (p_aw_block) else $error("write not blocked");
    property p_b_hold;
        s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_r_hold;
        s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    property p_ar_resp;
        s_arvalid && s_arready |=> s_rvalid && !s_arready;
    endproperty
    a_ar_resp: assert property (p_ar_resp) else $error("read answer late");
    property p_en_set;
        (slot_enable & ~$past(slot_enable)) != 8'h00 |-> s_bvalid;
    endproperty
    a_en_set: assert property (p_en_set) else $error("enable set by hardware");
    property p_en_keep;
        res_valid && !slot_enable[res_slot] && s_awready && !s_awvalid |=> $stable(slot_enable);
    endproperty
    a_en_keep: assert property (p_en_keep) else $error("idle slot touched");
    property p_irq_cause;
        $rose(irq) |-> $past(res_valid) || s_bvalid;
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
endmodule : pimr_top_props
bind pimr_top pimr_top_props u_props (.*);

// ### sim/pimr_top_tb.sv
// bench: slot results, register bus and interrupt
`timescale 1ns/1ps
module pimr_top_tb;
    logic        aclk, aresetn, res_valid, res_is_in, irq;
    logic [2:0]  res_slot, res_flags, f;
    logic [4:0]  res_frame;
    logic [11:0] res_count, c;
    logic [7:0]  slot_enable, s_awaddr, s_araddr;
    logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic        s_arvalid, s_arready, s_rvalid, s_rready;
    logic [31:0] s_wdata, s_rdata, d, e4, e5, e6;
    logic [3:0]  s_wstrb;
    logic [1:0]  s_bresp, s_rresp, rsp;
    int          miscompares = 0;
    int          checks_done = 0;
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    pimr_top dut (.res_xact_err(res_flags[0]), .res_babble(res_flags[1]), .res_underrun(res_flags[2]), .*);
    pimr_usb_model usb (.*);
    task automatic summarize();
        $display("checks_done %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
        checks_done++;
        if (g !== x) begin
            miscompares++;
            $display("[FAIL] %0t %s: got %h exp %h", $time, m, g, x);
        end
    endtask : chk
    // bready/rready come late on purpose so the answer must stand
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] st);
        int n;
        @(posedge aclk);
        {s_awaddr, s_wdata, s_wstrb, s_awvalid, s_wvalid} <= {a, v, st, 2'b11};
        for (n = 0; n < 20; n++) begin
            @(posedge aclk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
            if (n == 3) s_bready <= 1'b1;
            if (s_bvalid && s_bready) break;
        end
        if (n == 20) chk(0, 1, "write hung");
        if (n == 20) summarize();
        rsp = s_bresp;
        s_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        int n;
        @(posedge aclk);
        {s_araddr, s_arvalid} <= {a, 1'b1};
        for (n = 0; n < 20; n++) begin
            @(posedge aclk);
            if (s_arready) s_arvalid <= 1'b0;
            if (n == 2) s_rready <= 1'b1;
            if (s_rvalid && s_rready) break;
        end
        if (n == 20) chk(0, 1, "read hung");
        if (n == 20) summarize();
        {v, rsp} = {s_rdata, s_rresp};
        s_rready <= 1'b0;
    endtask : rd
    initial begin
        {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
        {s_awaddr, s_araddr, s_wdata, s_wstrb, e4, e5, e6} = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(pimr_pkg::ADDR_WORD4, d);
        chk(d, 32'h0000_0000, "reset");
        rd(8'h20, d);
        chk({d[29:0], rsp}, {30'h0, pimr_pkg::RESP_SLVERR}, "unmapped read");
        wr(8'h24, 32'hffffffff, 4'hf);
        chk({30'h0, rsp}, {30'h0, pimr_pkg::RESP_SLVERR}, "unmapped write");
        $display("test reset and map done");
        wr(pimr_pkg::ADDR_CTRL, 32'h1, 4'h1);
        wr(pimr_pkg::ADDR_FRAME, 32'h3, 4'h1);
        wr(pimr_pkg::ADDR_IRQ_MK, 32'hff, 4'h1);
        wr(pimr_pkg::ADDR_WORD4, 32'hff, 4'h1);
        chk({24'h0, slot_enable}, 32'hff, "enables set");
        for (int s = 0; s < 8; s++) begin
            c = 12'h9c3 ^ 12'(s * 'h111);
            f = 3'(s);
            usb.send(3'(s), 5'h03, c, f[0], f);
            if (s > 1) e4[8 + 3 * s +: 3] = {f[2] & ~f[0], f[1] & f[0], f[0]};
            case (s)
                0: e5[11:0] = c;
                1: e5[23:12] = c;
                2: {e5[31:24], e6[3:0]} = {c[7:0], c[11:8]};
                3: e6[15:4] = c;
                4: e6[27:16] = c;
                5: e6[31:28] = c[3:0];
                default: ;
            endcase
        end
        rd(pimr_pkg::ADDR_WORD4, d);
        chk(d, e4, "word four");
        rd(pimr_pkg::ADDR_WORD5, d);
        chk(d, e5, "word five");
        rd(pimr_pkg::ADDR_WORD6, d);
        chk(d, e6, "word six");
        chk({23'h0, slot_enable, irq}, 32'h1, "enables cleared");
        $display("test all slots done");
        usb.send(3'd3, 5'h03, 12'h000, 1'b1, 3'h1);
        wr(pimr_pkg::ADDR_WORD4, 32'h1, 4'h1);
        usb.send(3'd0, 5'h04, 12'h777, 1'b1, 3'h1);
        rd(pimr_pkg::ADDR_WORD6, d);
        chk(d, e6, "disabled slot");
        rd(pimr_pkg::ADDR_WORD5, d);
        chk(d, e5, "frame mismatch");
        usb.send(3'd0, 5'h03, 12'h5a5, 1'b0, 3'h0);
        e5[11:0] = 12'h5a5;
        rd(pimr_pkg::ADDR_WORD5, d);
        chk(d, e5, "slot zero");
        // result register: code 14:12, slot 11:9, marker bit 8, count low byte
        rd(pimr_pkg::ADDR_RESULT, d);
        chk(d, 32'h0000_01a5, "last result");
        rd(pimr_pkg::ADDR_WORD4, d);
        chk(d, e4, "word four kept");
        $display("test ignored results done");
        wr(pimr_pkg::ADDR_IRQ_ST, 32'h0f, 4'h1);
        rd(pimr_pkg::ADDR_IRQ_ST, d);
        chk({d[30:0], irq}, 32'h1e1, "status partly cleared");
        wr(pimr_pkg::ADDR_IRQ_MK, 32'h0f, 4'h1);
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(pimr_pkg::ADDR_IRQ_ST, 32'hff, 4'h1);
        rd(pimr_pkg::ADDR_IRQ_ST, d);
        chk(d, 32'h0, "status cleared");
        $display("test interrupt done");
        summarize();
    end
endmodule : pimr_top_tb
